//--- rdca_host_model.sv
// rdca_host_model: host side of the sixteen two-way angle lines
`timescale 1ns/10ps
`default_nettype none

module rdca_host_model (
  input wire logic clk_sys_i,
  input wire logic [rdca_pkg::ANGLE_W-1:0] dev_angle_i,
  input wire logic dev_oe_i,
  input wire logic host_drive_i,
  input wire logic [rdca_pkg::ANGLE_W-1:0] host_val_i,
  output logic [rdca_pkg::ANGLE_W-1:0] line_o
);
  // ----------------------------------------------------------------
  // resolved level of the lines
  // ----------------------------------------------------------------
  logic [rdca_pkg::ANGLE_W-1:0] last_r;

  // no pull on the lines: a released bus shows the inverse of the
  // last driven word, so a stale value never reads back as good
  always_comb
  begin
    if (dev_oe_i)
      line_o = dev_angle_i;
    else if (host_drive_i)
      line_o = host_val_i;
    else
      line_o = ~last_r;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (dev_oe_i || host_drive_i)
      last_r <= line_o;
  end
endmodule : rdca_host_model
`default_nettype wire

//--- rdca_pkg.sv
// rdca_pkg: constants and types of the tracking angle counter
package rdca_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ANGLE_W = 16;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned PIN_W = 21;

  // ----------------------------------------------------------------
  // register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] REG_TARGET = 8'h04;
  localparam logic [ADR_W-1:0] REG_RATE = 8'h08;
  localparam logic [ADR_W-1:0] REG_ANGLE = 8'h0C;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h10;

  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned ST_DIR_BIT = 0;
  localparam int unsigned ST_RES_LSB = 1;
  localparam int unsigned ST_BAND_BIT = 3;
  localparam int unsigned ST_PRESET_BIT = 4;
  localparam int unsigned ST_FREEZE_BIT = 5;
  localparam int unsigned ST_OE_BIT = 6;

  // ----------------------------------------------------------------
  // reset values and step weights
  // ----------------------------------------------------------------
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam logic [ANGLE_W-1:0] TARGET_RST = 16'h0000;
  localparam logic [ANGLE_W-1:0] RATE_RST = 16'h0000;
  localparam logic [ANGLE_W-1:0] ANGLE_RST = 16'h0000;
  localparam logic [ANGLE_W-1:0] LSB_10 = 16'h0040;
  localparam logic [ANGLE_W-1:0] LSB_12 = 16'h0010;
  localparam logic [ANGLE_W-1:0] LSB_14 = 16'h0004;
  localparam logic [ANGLE_W-1:0] LSB_16 = 16'h0001;
  localparam logic [DAT_W-1:0] RD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RES_10, RES_12, RES_14, RES_16} rdca_res_t;
  typedef enum logic {BUS_IDLE, BUS_ACK} rdca_bus_st_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } rdca_wb_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [DAT_W-1:0] dat;
  } rdca_wb_rsp_t;

  typedef struct packed {
    logic res_hi;
    logic res_lo;
    logic freeze_n;
    logic preset_n;
    logic enable_n;
    logic [ANGLE_W-1:0] angle;
  } rdca_pins_t;

  localparam rdca_pins_t PINS_RST = '{res_hi: 1'b0, res_lo: 1'b0,
    freeze_n: 1'b1, preset_n: 1'b1, enable_n: 1'b1, angle: ANGLE_RST};

endpackage : rdca_pkg

//--- rdca_rate_osc.sv
// rdca_rate_osc: rate oscillator, step pulses proportional to rate
`timescale 1ns/10ps
`default_nettype none

module rdca_rate_osc (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic en_i,
  input wire logic [rdca_pkg::ANGLE_W-1:0] rate_i,
  output logic step_o
);

  logic [rdca_pkg::ANGLE_W-1:0] acc_r;
  logic [rdca_pkg::ANGLE_W:0] sum_w;

  // carry out of the phase sum is the step: mean rate = rate/65536
  assign sum_w = {1'b0, acc_r} + {1'b0, rate_i};

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || !en_i)
    begin
      acc_r <= rdca_pkg::ANGLE_RST;
      step_o <= 1'b0;
    end
    else
    begin
      acc_r <= sum_w[rdca_pkg::ANGLE_W-1:0];
      step_o <= sum_w[rdca_pkg::ANGLE_W];
    end
  end

endmodule : rdca_rate_osc

`default_nettype wire

//--- rdca_sync.sv
// rdca_sync: two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none

module rdca_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  // meta_r feeds q_o only
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule : rdca_sync

`default_nettype wire

//--- rdca_top.sv
// rdca_top: tracking angle counter with parallel angle output
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - angle appears on sixteen two-way lines, natural binary, positive.
// - first line is the MSB worth half a turn, each next halves.
// - ten-bit setting: line ten is LSB, lines eleven to sixteen zero.
// - twelve-bit setting: line twelve is LSB, thirteen to sixteen zero.
// - fourteen-bit setting: line fourteen is LSB, fifteen, sixteen zero.
// - sixteen-bit setting: all lines active, line sixteen is LSB.
// - select pins 00,01,10,11 choose 10,12,14,16 bits.
// - lines driven only while output enable is low, else released.
// - no counting while error magnitude is below one LSB.
// - counter steps toward target along error sign until error nulls.
// - count rate is proportional to the velocity word.
// - freeze low holds the angle output stable for reading.
// - preset low makes lines inputs that load the counter.
// - busy pulses high each time the angle changes by one LSB.

module rdca_top (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire rdca_pkg::rdca_wb_req_t wb_req_i,
  output rdca_pkg::rdca_wb_rsp_t wb_rsp_o,
  input wire logic resolution_select_hi_i,
  input wire logic resolution_select_lo_i,
  input wire logic angle_freeze_n_i,
  input wire logic angle_preset_n_i,
  input wire logic angle_out_enable_n_i,
  input wire logic [rdca_pkg::ANGLE_W-1:0] angle_i,
  output logic [rdca_pkg::ANGLE_W-1:0] angle_o,
  output logic angle_oe_o,
  output logic busy_o,
  output logic count_direction_o,
  output logic turns_ripple_n_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  rdca_pkg::rdca_pins_t pins_w;
  rdca_pkg::rdca_pins_t pins_s;

  assign pins_w = '{res_hi: resolution_select_hi_i,
    res_lo: resolution_select_lo_i, freeze_n: angle_freeze_n_i,
    preset_n: angle_preset_n_i, enable_n: angle_out_enable_n_i,
    angle: angle_i};

  rdca_sync #(
    .W(rdca_pkg::PIN_W),
    .RST_VAL(rdca_pkg::PINS_RST)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .d_i(pins_w),
    .q_o(pins_s)
  );

  // ----------------------------------------------------------------
  // resolution decode
  // ----------------------------------------------------------------
  rdca_pkg::rdca_res_t res_code;
  logic [rdca_pkg::ANGLE_W-1:0] lsb_w;
  logic [rdca_pkg::ANGLE_W-1:0] mask_w;

  assign res_code = rdca_pkg::rdca_res_t'({pins_s.res_hi,
    pins_s.res_lo});
  assign lsb_w = (res_code == rdca_pkg::RES_10) ? rdca_pkg::LSB_10 :
    (res_code == rdca_pkg::RES_12) ? rdca_pkg::LSB_12 :
    (res_code == rdca_pkg::RES_14) ? rdca_pkg::LSB_14 :
    rdca_pkg::LSB_16;
  // unused low lines forced to zero
  assign mask_w = ~(lsb_w - rdca_pkg::LSB_16);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic run_r;
  logic [rdca_pkg::ANGLE_W-1:0] target_r;
  logic [rdca_pkg::ANGLE_W-1:0] rate_r;
  logic [rdca_pkg::ANGLE_W-1:0] angle_r;
  logic [rdca_pkg::ANGLE_W-1:0] angle_nxt;
  rdca_pkg::rdca_bus_st_t bus_st_r;

  // ----------------------------------------------------------------
  // tracking error and hysteresis
  // ----------------------------------------------------------------
  logic [rdca_pkg::ANGLE_W-1:0] err_w;
  logic [rdca_pkg::ANGLE_W-1:0] err_mag;
  logic err_neg;
  logic in_band;
  logic step_pulse;
  logic step_en;
  logic cnt_up;
  logic [rdca_pkg::ANGLE_W-1:0] step_val;
  logic zero_cross;

  // modular difference takes the short way round the turn
  assign err_w = (target_r & mask_w) - angle_r;
  assign err_neg = err_w[rdca_pkg::ANGLE_W-1];
  assign err_mag = err_neg ? 16'(~err_w + rdca_pkg::LSB_16) : err_w;
  assign in_band = err_mag < lsb_w;
  assign cnt_up = !err_neg;

  rdca_rate_osc u_osc (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .en_i(run_r),
    .rate_i(rate_r),
    .step_o(step_pulse)
  );

  // preset owns the counter; no counting inside the dead band
  assign step_en = step_pulse && !in_band && pins_s.preset_n;
  assign step_val = cnt_up ? 16'(angle_r + lsb_w) :
    16'(angle_r - lsb_w);
  assign zero_cross = cnt_up ? ((step_val & mask_w) == '0) :
    (angle_r == '0);

  always_comb
  begin
    angle_nxt = angle_r;
    if (!pins_s.preset_n)
    begin
      angle_nxt = pins_s.angle;
    end
    else if (step_en)
    begin
      angle_nxt = step_val;
    end
    angle_nxt = angle_nxt & mask_w;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      angle_r <= rdca_pkg::ANGLE_RST;
    end
    else
    begin
      angle_r <= angle_nxt;
    end
  end

  // ----------------------------------------------------------------
  // angle lines and pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      angle_o <= rdca_pkg::ANGLE_RST;
      angle_oe_o <= 1'b0;
      busy_o <= 1'b0;
      count_direction_o <= 1'b1;
      turns_ripple_n_o <= 1'b1;
    end
    else
    begin
      if (pins_s.freeze_n)
      begin
        angle_o <= angle_nxt;
      end
      // lines released while preset drives them from outside
      angle_oe_o <= !pins_s.enable_n && pins_s.preset_n;
      busy_o <= step_en;
      if (step_en)
      begin
        count_direction_o <= cnt_up;
      end
      turns_ripple_n_o <= !(step_en && zero_cross);
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic bus_req;
  logic adr_hit;
  logic wr_ctrl;
  logic wr_target;
  logic wr_rate;
  logic [rdca_pkg::DAT_W-1:0] rd_w;
  logic [rdca_pkg::DAT_W-1:0] status_w;
  logic [rdca_pkg::ANGLE_W-1:0] target_wm;
  logic [rdca_pkg::ANGLE_W-1:0] rate_wm;

  assign bus_req = wb_req_i.cyc && wb_req_i.stb &&
    (bus_st_r == rdca_pkg::BUS_IDLE);
  assign adr_hit = (wb_req_i.adr == rdca_pkg::REG_CTRL) ||
    (wb_req_i.adr == rdca_pkg::REG_TARGET) ||
    (wb_req_i.adr == rdca_pkg::REG_RATE) ||
    (wb_req_i.adr == rdca_pkg::REG_ANGLE) ||
    (wb_req_i.adr == rdca_pkg::REG_STATUS);
  assign wr_ctrl = bus_req && wb_req_i.we && wb_req_i.sel[0] &&
    (wb_req_i.adr == rdca_pkg::REG_CTRL);
  assign wr_target = bus_req && wb_req_i.we &&
    (wb_req_i.adr == rdca_pkg::REG_TARGET);
  assign wr_rate = bus_req && wb_req_i.we &&
    (wb_req_i.adr == rdca_pkg::REG_RATE);

  // byte lanes merge into the 16-bit registers
  genvar gb;
  generate
    for (gb = 0; gb < 2; gb++)
    begin : g_lane
      assign target_wm[gb*8 +: 8] = wb_req_i.sel[gb] ?
        wb_req_i.dat[gb*8 +: 8] : target_r[gb*8 +: 8];
      assign rate_wm[gb*8 +: 8] = wb_req_i.sel[gb] ?
        wb_req_i.dat[gb*8 +: 8] : rate_r[gb*8 +: 8];
    end
  endgenerate

  always_comb
  begin
    status_w = rdca_pkg::RD_ZERO;
    status_w[rdca_pkg::ST_DIR_BIT] = count_direction_o;
    status_w[rdca_pkg::ST_RES_LSB +: 2] = res_code;
    status_w[rdca_pkg::ST_BAND_BIT] = in_band;
    status_w[rdca_pkg::ST_PRESET_BIT] = !pins_s.preset_n;
    status_w[rdca_pkg::ST_FREEZE_BIT] = !pins_s.freeze_n;
    status_w[rdca_pkg::ST_OE_BIT] = angle_oe_o;
  end

  assign rd_w =
    (wb_req_i.adr == rdca_pkg::REG_CTRL) ?
      32'(run_r) :
    (wb_req_i.adr == rdca_pkg::REG_TARGET) ? 32'(target_r) :
    (wb_req_i.adr == rdca_pkg::REG_RATE) ? 32'(rate_r) :
    (wb_req_i.adr == rdca_pkg::REG_ANGLE) ? 32'(angle_r) :
    (wb_req_i.adr == rdca_pkg::REG_STATUS) ? status_w :
    rdca_pkg::RD_ZERO;

  // answer one cycle after the request, then one idle cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      bus_st_r <= rdca_pkg::BUS_IDLE;
      wb_rsp_o <= '0;
    end
    else
    begin
      unique case (bus_st_r)
        rdca_pkg::BUS_IDLE:
        begin
          if (bus_req)
          begin
            bus_st_r <= rdca_pkg::BUS_ACK;
            wb_rsp_o.ack <= adr_hit;
            wb_rsp_o.err <= !adr_hit;
            wb_rsp_o.dat <= rd_w;
          end
        end
        rdca_pkg::BUS_ACK:
        begin
          bus_st_r <= rdca_pkg::BUS_IDLE;
          wb_rsp_o <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      run_r <= rdca_pkg::CTRL_RUN_RST;
      target_r <= rdca_pkg::TARGET_RST;
      rate_r <= rdca_pkg::RATE_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        run_r <= wb_req_i.dat[rdca_pkg::CTRL_RUN_BIT];
      end
      if (wr_target)
      begin
        target_r <= target_wm;
      end
      if (wr_rate)
      begin
        rate_r <= rate_wm;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence seq_preset_held;
    !pins_s.preset_n [*2];
  endsequence

  sequence seq_answer;
    (wb_rsp_o.ack || wb_rsp_o.err) ##1 !(wb_rsp_o.ack || wb_rsp_o.err);
  endsequence

  AST_OE_FOLLOWS_ENABLE: assert property (
    angle_oe_o == $past(!pins_s.enable_n && pins_s.preset_n))
    else $error("angle lines driven while output enable high");

  AST_RES10_LOW_ZERO: assert property (
    (res_code == rdca_pkg::RES_10) |=>
      ((angle_r & 16'(rdca_pkg::LSB_10 - rdca_pkg::LSB_16)) == '0))
    else $error("low six lines not zero at ten bits");

  AST_LOW_LINES_ZERO: assert property (
    (angle_r & ~$past(mask_w)) == '0)
    else $error("unused low lines not zero");

  AST_DEAD_BAND_HOLD: assert property (
    ($stable(res_code) && in_band && pins_s.preset_n) |=>
      (angle_r == $past(angle_r)))
    else $error("counter moved inside dead band");

  AST_DIR_FOLLOWS_ERR: assert property (
    (step_en && !err_neg) |=> count_direction_o)
    else $error("direction not up for positive error");

  AST_BUSY_ON_CHANGE: assert property (
    busy_o |-> (angle_r != $past(angle_r)))
    else $error("busy pulse without angle change");

  AST_RIPPLE_AT_ZERO: assert property (
    !turns_ripple_n_o |-> ((angle_r == '0 && count_direction_o) ||
      ($past(angle_r) == '0 && !count_direction_o)))
    else $error("ripple pulse away from zero");

  AST_WRAP_UP: assert property (
    (step_en && cnt_up && angle_r == mask_w && $stable(res_code))
      |=> (angle_r == '0))
    else $error("counter did not wrap to zero");

  AST_FREEZE_HOLD: assert property (
    !pins_s.freeze_n |=> $stable(angle_o))
    else $error("angle output moved while frozen");

  AST_PRESET_LOAD: assert property (
    seq_preset_held |-> (!angle_oe_o &&
      angle_r == ($past(pins_s.angle) & $past(mask_w))))
    else $error("preset did not load counter");

  AST_RATE_ZERO_STILL: assert property (
    (rate_r == '0) [*2] |-> !step_pulse)
    else $error("step pulse with zero rate");

  AST_WB_ANSWER: assert property (
    (bus_req) |=> seq_answer)
    else $error("bus request not answered in one cycle");

endmodule : rdca_top

`default_nettype wire

//--- tracking_angle_counter_output_tb.sv
// tracking_angle_counter_output_tb: self-checking bench of rdca_top
`timescale 1ns/10ps
`default_nettype none

module tracking_angle_counter_output_tb;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  rdca_pkg::rdca_wb_req_t req = '0;
  rdca_pkg::rdca_wb_rsp_t rsp;
  logic sel_hi = 1'b1;
  logic sel_lo = 1'b1;
  logic freeze_n = 1'b1;
  logic preset_n = 1'b1;
  logic enable_n = 1'b0;
  logic host_drive = 1'b0;
  logic [15:0] host_val = 16'h0000;
  logic [15:0] line;
  logic [15:0] dev_angle;
  logic oe, busy, dir, ripple_n;
  int bad_count = 0;
  int checks_done = 0;
  int busy_cnt = 0;
  int ripple_cnt = 0;
  int seed = 49;
  logic [31:0] q;
  logic e;
  logic [3:0] wsel = 4'hf;
  logic [7:0] rst_adr [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [31:0] rst_val [5] = '{32'h0000_0001, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_004f};

  always #50 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i)
  begin
    if (busy === 1'b1) busy_cnt++;
    if (ripple_n === 1'b0) ripple_cnt++;
  end

  rdca_top u_rdca_top (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .wb_req_i(req), .wb_rsp_o(rsp),
    .resolution_select_hi_i(sel_hi), .resolution_select_lo_i(sel_lo),
    .angle_freeze_n_i(freeze_n), .angle_preset_n_i(preset_n),
    .angle_out_enable_n_i(enable_n), .angle_i(line),
    .angle_o(dev_angle), .angle_oe_o(oe), .busy_o(busy),
    .count_direction_o(dir), .turns_ripple_n_o(ripple_n)
  );

  rdca_host_model u_rdca_host_model (
    .clk_sys_i(clk_sys_i), .dev_angle_i(dev_angle), .dev_oe_i(oe),
    .host_drive_i(host_drive), .host_val_i(host_val), .line_o(line)
  );

  // ----------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------
  function automatic logic [15:0] lsb_of(input logic [1:0] c);
    return 16'h0001 << (2 * (3 - int'(c)));
  endfunction : lsb_of

  function automatic logic [15:0] mask_of(input logic [1:0] c);
    return ~(lsb_of(c) - 16'h0001);
  endfunction : mask_of

  // short way round, in steps of the selected resolution
  function automatic int steps(input logic [15:0] f,
    input logic [15:0] t, input logic [1:0] c);
    logic [15:0] d;
    d = t - f;
    if (d[15])
      d = -d;
    return int'(d / lsb_of(c));
  endfunction : steps

  // ----------------------------------------------------------------
  // checks, bus cycles and run control
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string msg);
    checks_done++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %0t %s", $time, msg);
      bad_count++;
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    req.cyc <= 1'b1;
    req.stb <= 1'b1;
    req.we <= w;
    req.adr <= a;
    req.sel <= wsel;
    req.dat <= d;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (rsp.ack !== 1'b1 && rsp.err !== 1'b1 && n < 100);
    if (n >= 100)
      chk(32'h0000_0000, 32'h0000_0001, "bus answer missing");
    q = rsp.dat;
    e = rsp.err;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask : wb

  // pin changes show at the outputs three edges later
  task automatic settle;
    repeat (4) @(posedge clk_sys_i);
  endtask : settle

  task automatic track(input logic [15:0] t);
    int n;
    wb(1'b1, rdca_pkg::REG_TARGET, {16'h0000, t});
    n = 0;
    do
    begin
      wb(1'b0, rdca_pkg::REG_ANGLE, 32'h0000_0000);
      n++;
    end
    while (q[15:0] !== t && n < 3000);
  endtask : track

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin : main
    logic [15:0] t, cur, lsb, m, a;
    logic [1:0] code;
    int k;
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    foreach (rst_adr[i])
    begin
      wb(1'b0, rst_adr[i], 32'h0000_0000);
      chk(q, rst_val[i], "reset value");
    end
    wb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001, "unmapped not refused");
    wb(1'b1, rdca_pkg::REG_ANGLE, 32'h0000_1234);
    wb(1'b0, rdca_pkg::REG_ANGLE, 32'h0000_0000);
    chk(q, 32'h0000_0000, "read-only angle written");
    wb(1'b1, rdca_pkg::REG_RATE, 32'h0000_ffff);
    cur = 16'h0000;
    for (k = 0; k < 4; k++)
    begin
      code = 2'(3 - k);
      lsb = lsb_of(code);
      m = mask_of(code);
      @(posedge clk_sys_i);
      sel_hi <= code[1];
      sel_lo <= code[0];
      settle();
      cur = cur & m;
      wb(1'b0, rdca_pkg::REG_ANGLE, 32'h0000_0000);
      chk({16'h0000, q[15:0]}, {16'h0000, cur}, "remask");
      t = 16'($random(seed)) & 16'h0fff & m;
      busy_cnt = 0;
      track(t);
      chk({16'h0000, q[15:0]}, {16'h0000, t}, "tracked");
      chk(32'(busy_cnt), 32'(steps(cur, t, code)), "steps");
      chk({16'h0000, line}, {16'h0000, t}, "lines");
      chk({16'h0000, line & ~m}, 32'h0000_0000, "low");
      busy_cnt = 0;
      wb(1'b1, rdca_pkg::REG_TARGET, {16'h0000, t + lsb - 16'h0001});
      repeat (20) @(posedge clk_sys_i);
      chk(32'(busy_cnt), 32'h0000_0000, "dead band count");
      cur = t;
    end
    track(16'h0000);
    ripple_cnt = 0;
    track(16'h0000 - lsb);
    chk({16'h0000, q[15:0]}, {16'h0000, 16'hffc0}, "down wrap");
    chk(32'(ripple_cnt), 32'h0000_0001, "ripple down");
    chk({31'h0000_0000, dir}, 32'h0000_0000, "dir down");
    track(lsb);
    chk({16'h0000, q[15:0]}, {16'h0000, lsb}, "up wrap");
    chk(32'(ripple_cnt), 32'h0000_0002, "ripple up");
    chk({31'h0000_0000, dir}, 32'h0000_0001, "dir up");
    @(posedge clk_sys_i);
    sel_hi <= 1'b1;
    sel_lo <= 1'b1;
    settle();
    wb(1'b1, rdca_pkg::REG_RATE, 32'h0000_1000);
    wb(1'b1, rdca_pkg::REG_TARGET, 32'h0000_4000);
    busy_cnt = 0;
    repeat (1600) @(posedge clk_sys_i);
    chk(32'(busy_cnt >= 98 && busy_cnt <= 102), 32'h0000_0001,
      "rate");
    // byte lanes: no lane 0 leaves run alone, lane 0 alone hits rate low
    wsel = 4'h0;
    wb(1'b1, rdca_pkg::REG_CTRL, 32'h0000_0000);
    wsel = 4'h1;
    wb(1'b1, rdca_pkg::REG_RATE, 32'h0000_ff55);
    wsel = 4'hf;
    wb(1'b0, rdca_pkg::REG_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0001, "ctrl lane gate");
    wb(1'b0, rdca_pkg::REG_RATE, 32'h0000_0000);
    chk(q, 32'h0000_1055, "rate low lane");
    wb(1'b1, rdca_pkg::REG_RATE, 32'h0000_1000);
    wb(1'b1, rdca_pkg::REG_CTRL, 32'h0000_0000);
    // a step launched just before the write still pulses busy
    repeat (2) @(posedge clk_sys_i);
    busy_cnt = 0;
    repeat (100) @(posedge clk_sys_i);
    chk(32'(busy_cnt), 32'h0000_0000, "run off");
    wb(1'b1, rdca_pkg::REG_CTRL, 32'h0000_0001);
    @(posedge clk_sys_i);
    freeze_n <= 1'b0;
    settle();
    a = dev_angle;
    repeat (100) @(posedge clk_sys_i);
    chk({16'h0000, dev_angle}, {16'h0000, a}, "frozen");
    wb(1'b0, rdca_pkg::REG_ANGLE, 32'h0000_0000);
    chk(32'(q[15:0] != a), 32'h0000_0001, "counter stopped");
    wb(1'b0, rdca_pkg::REG_STATUS, 32'h0000_0000);
    chk(q & 32'h0000_0030, 32'h0000_0020, "freeze status");
    t = 16'($random(seed));
    @(posedge clk_sys_i);
    freeze_n <= 1'b1;
    preset_n <= 1'b0;
    host_drive <= 1'b1;
    host_val <= t;
    settle();
    chk({31'h0000_0000, oe}, 32'h0000_0000, "preset drive");
    repeat (20) @(posedge clk_sys_i);
    wb(1'b0, rdca_pkg::REG_ANGLE, 32'h0000_0000);
    chk({16'h0000, q[15:0]}, {16'h0000, t}, "preset load");
    wb(1'b0, rdca_pkg::REG_STATUS, 32'h0000_0000);
    chk(q & 32'h0000_0070, 32'h0000_0010, "preset status");
    @(posedge clk_sys_i);
    preset_n <= 1'b1;
    host_drive <= 1'b0;
    enable_n <= 1'b1;
    settle();
    chk({31'h0000_0000, oe}, 32'h0000_0000, "not released");
    @(posedge clk_sys_i);
    enable_n <= 1'b0;
    settle();
    chk({31'h0000_0000, oe}, 32'h0000_0001, "not driven");
    chk({16'h0000, line}, {16'h0000, dev_angle}, "line level");
    complete_run();
  end

  initial
  begin : watchdog
    #4000000;
    bad_count++;
    complete_run();
  end
endmodule : tracking_angle_counter_output_tb
`default_nettype wire
